// File: inc/lvcfg_pkg.sv
// Purpose: Shared constants for the output channel configuration bank.
// Assumes: APB with 32-bit data; each register index maps to byte address index*4.
// Notes:   Field positions and reset values live here only.

package lvcfg_pkg;

  localparam int ADDR_W = 12;
  localparam int LANES  = 5;

  // Register indices; byte address is the index times four.
  localparam logic [7:0] IDX_SWING_CM   = 8'h19;
  localparam logic [7:0] IDX_ORDER_TERM = 8'h1a;
  localparam logic [7:0] IDX_CM_TRIM    = 8'h1b;
  localparam logic [7:0] IDX_LEN_LO     = 8'h20;
  localparam logic [7:0] IDX_LEN_HI     = 8'h21;
  localparam logic [7:0] IDX_STATUS     = 8'h30;

  localparam logic [ADDR_W-1:0] ADDR_SWING_CM   = {2'h0, IDX_SWING_CM, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_ORDER_TERM = {2'h0, IDX_ORDER_TERM, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_CM_TRIM    = {2'h0, IDX_CM_TRIM, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_LEN_LO     = {2'h0, IDX_LEN_LO, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_LEN_HI     = {2'h0, IDX_LEN_HI, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_STATUS     = {2'h0, IDX_STATUS, 2'h0};

  // Field positions.
  localparam int POS_CM_SEL    = 6;
  localparam int POS_SWING     = 2;
  localparam int POS_FLIP      = 5;
  localparam int POS_TERM      = 1;
  localparam int POS_TRIM      = 4;
  localparam int POS_LEN_HI    = 0;
  localparam int POS_MISMATCH  = 0;
  localparam int POS_FLIP_STAT = 1;

  // Values after reset.
  localparam logic       RST_CM_SEL = 1'h0;
  localparam logic [1:0] RST_SWING  = 2'h1;
  localparam logic       RST_FLIP   = 1'h0;
  localparam logic       RST_TERM   = 1'h1;
  localparam logic [1:0] RST_TRIM   = 2'h0;
  localparam logic [7:0] RST_LEN_LO = 8'h00;
  localparam logic [3:0] RST_LEN_HI = 4'h0;

  // Trim code that the low common-mode setting expects.
  localparam logic [1:0] TRIM_FOR_LOW_CM = 2'h1;

  // Lane order when reversed: entry i is the source lane for output i.
  // Lane 4 is the clock lane.
  localparam logic [14:0] REV_SRC = {3'h1, 3'h0, 3'h2, 3'h4, 3'h3};

  typedef enum logic [2:0] {
    LVCFG_SEL_NONE   = 3'b000,
    LVCFG_SEL_SWING  = 3'b001,
    LVCFG_SEL_ORDER  = 3'b010,
    LVCFG_SEL_TRIM   = 3'b011,
    LVCFG_SEL_LEN_LO = 3'b100,
    LVCFG_SEL_LEN_HI = 3'b101,
    LVCFG_SEL_STATUS = 3'b110
  } lvcfg_sel_t;

endpackage : lvcfg_pkg

// File: hw/lvcfg_lane_remap.sv
// Purpose: Registered lane order switch for the output channel pins.
// Assumes: Lane inputs come from the serializer on core_clk.
// Notes:   Pos and neg of a lane always travel together.

`timescale 1ns/10ps
`default_nettype none

module lvcfg_lane_remap
  import lvcfg_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             srst,
  input  wire logic             flip,
  input  wire logic [LANES-1:0] in_pos,
  input  wire logic [LANES-1:0] in_neg,
  output logic      [LANES-1:0] out_pos,
  output logic      [LANES-1:0] out_neg
);

  logic [LANES-1:0] next_out_pos;
  logic [LANES-1:0] next_out_neg;

  for (genvar i = 0; i < LANES; i++) begin : g_lane
    localparam int SRC = int'(REV_SRC[3*i +: 3]);
    assign next_out_pos[i] = flip ? in_pos[SRC] : in_pos[i];
    assign next_out_neg[i] = flip ? in_neg[SRC] : in_neg[i];
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      out_pos <= '0;
      out_neg <= '0;
    end else begin
      out_pos <= next_out_pos;
      out_neg <= next_out_neg;
    end
  end

endmodule : lvcfg_lane_remap

`default_nettype wire

// File: hw/lvcfg_regs.sv
// Purpose: Configuration bank for the single output channel, on APB.
// Assumes: Zero wait states; read data is captured in the setup cycle.
// Notes:   Reserved bits are not stored, so they read as zero.

`timescale 1ns/10ps
`default_nettype none

// Function
// - Bit 6 of the swing register picks 1.2 V common mode when clear and 0.9 V when set.
// - Bits 3 to 2 of the swing register hold a four-code swing select that resets to 01.
// - Bit 5 of the order register reverses lane order; clear keeps the normal order.
// - Reversed order swaps data lane 0 with 3 and lane 1 with the clock, lane 2 stays.
// - Bit 1 of the order register picks 100 or 200 ohm termination and resets to 1.
// - Bits 5 to 4 of the trim register hold the common-mode trim code, reset 00.
// - The low length register holds line length bits 7 to 0, reset zero.
// - The low length register is the low eight bits of a twelve-bit pixel count.
// - Bits 3 to 0 of the next register give the upper four length bits.
module lvcfg_regs
  import lvcfg_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              srst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [LANES-1:0]  ser_lane_pos,
  input  wire logic [LANES-1:0]  ser_lane_neg,
  output logic                   out_lane0_pos,
  output logic                   out_lane0_neg,
  output logic                   out_lane1_pos,
  output logic                   out_lane1_neg,
  output logic                   out_lane2_pos,
  output logic                   out_lane2_neg,
  output logic                   out_lane3_pos,
  output logic                   out_lane3_neg,
  output logic                   out_clock_pos,
  output logic                   out_clock_neg,
  output logic                   common_mode_select,
  output logic      [1:0]        diff_swing_select,
  output logic                   lane_order_flip,
  output logic                   near_end_termination_select,
  output logic      [1:0]        common_mode_trim,
  output logic      [11:0]       line_pixel_count,
  output logic                   common_mode_trim_mismatch
);

  logic [7:0]       line_pixel_count_lo;
  logic [3:0]       line_pixel_count_hi;
  logic             next_common_mode_select;
  logic [1:0]       next_diff_swing_select;
  logic             next_lane_order_flip;
  logic             next_near_end_termination_select;
  logic [1:0]       next_common_mode_trim;
  logic [7:0]       next_line_pixel_count_lo;
  logic [3:0]       next_line_pixel_count_hi;
  logic             next_common_mode_trim_mismatch;
  logic [31:0]      next_prdata;
  lvcfg_sel_t       sel;
  logic             setup_phase;
  logic             access_phase;
  logic             wr_en;
  logic [7:0]       wbyte;
  logic [31:0]      rd_value;
  logic [LANES-1:0] pin_pos;
  logic [LANES-1:0] pin_neg;

  // Address decode.
  always_comb begin
    if (paddr == ADDR_SWING_CM) begin
      sel = LVCFG_SEL_SWING;
    end else if (paddr == ADDR_ORDER_TERM) begin
      sel = LVCFG_SEL_ORDER;
    end else if (paddr == ADDR_CM_TRIM) begin
      sel = LVCFG_SEL_TRIM;
    end else if (paddr == ADDR_LEN_LO) begin
      sel = LVCFG_SEL_LEN_LO;
    end else if (paddr == ADDR_LEN_HI) begin
      sel = LVCFG_SEL_LEN_HI;
    end else if (paddr == ADDR_STATUS) begin
      sel = LVCFG_SEL_STATUS;
    end else begin
      sel = LVCFG_SEL_NONE;
    end
  end

  // Every access completes in its first access cycle.
  assign pready       = 1'b1;
  assign setup_phase  = psel && !penable;
  assign access_phase = psel && penable;
  assign pslverr      = access_phase && (sel == LVCFG_SEL_NONE);

  // Only byte lane 0 carries register bits; a write without it changes nothing.
  assign wr_en = access_phase && pwrite && pstrb[0];
  assign wbyte = pwdata[7:0];

  // Read value; unstored bit positions come back as zero.
  always_comb begin
    rd_value = 32'h0000_0000;
    case (sel)
      LVCFG_SEL_SWING: begin
        rd_value[POS_CM_SEL]       = common_mode_select;
        rd_value[POS_SWING +: 2]   = diff_swing_select;
      end
      LVCFG_SEL_ORDER: begin
        rd_value[POS_FLIP]         = lane_order_flip;
        rd_value[POS_TERM]         = near_end_termination_select;
      end
      LVCFG_SEL_TRIM: begin
        rd_value[POS_TRIM +: 2]    = common_mode_trim;
      end
      LVCFG_SEL_LEN_LO: begin
        rd_value[7:0]              = line_pixel_count_lo;
      end
      LVCFG_SEL_LEN_HI: begin
        rd_value[POS_LEN_HI +: 4]  = line_pixel_count_hi;
      end
      LVCFG_SEL_STATUS: begin
        rd_value[POS_MISMATCH]     = common_mode_trim_mismatch;
        rd_value[POS_FLIP_STAT]    = lane_order_flip;
      end
      default: begin
        rd_value = 32'h0000_0000;
      end
    endcase
  end

  // Next register values.
  always_comb begin
    next_common_mode_select          = common_mode_select;
    next_diff_swing_select           = diff_swing_select;
    next_lane_order_flip             = lane_order_flip;
    next_near_end_termination_select = near_end_termination_select;
    next_common_mode_trim            = common_mode_trim;
    next_line_pixel_count_lo         = line_pixel_count_lo;
    next_line_pixel_count_hi         = line_pixel_count_hi;
    if (wr_en) begin
      case (sel)
        LVCFG_SEL_SWING: begin
          next_common_mode_select = wbyte[POS_CM_SEL];
          next_diff_swing_select  = wbyte[POS_SWING +: 2];
        end
        LVCFG_SEL_ORDER: begin
          next_lane_order_flip             = wbyte[POS_FLIP];
          next_near_end_termination_select = wbyte[POS_TERM];
        end
        LVCFG_SEL_TRIM: begin
          next_common_mode_trim = wbyte[POS_TRIM +: 2];
        end
        LVCFG_SEL_LEN_LO: begin
          next_line_pixel_count_lo = wbyte;
        end
        LVCFG_SEL_LEN_HI: begin
          next_line_pixel_count_hi = wbyte[POS_LEN_HI +: 4];
        end
        default: begin
          next_line_pixel_count_hi = line_pixel_count_hi;
        end
      endcase
    end
    // Flags a low common mode whose trim is not the code that setting
    // expects; software may get this wrong, so the state is made visible.
    next_common_mode_trim_mismatch =
      next_common_mode_select && (next_common_mode_trim != TRIM_FOR_LOW_CM);
    // Capturing in setup keeps prdata on a flop yet valid in the access cycle.
    next_prdata = setup_phase ? rd_value : prdata;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      common_mode_select          <= RST_CM_SEL;
      diff_swing_select           <= RST_SWING;
      lane_order_flip             <= RST_FLIP;
      near_end_termination_select <= RST_TERM;
      common_mode_trim            <= RST_TRIM;
      line_pixel_count_lo         <= RST_LEN_LO;
      line_pixel_count_hi         <= RST_LEN_HI;
      common_mode_trim_mismatch   <= 1'b0;
      prdata                      <= 32'h0000_0000;
    end else begin
      common_mode_select          <= next_common_mode_select;
      diff_swing_select           <= next_diff_swing_select;
      lane_order_flip             <= next_lane_order_flip;
      near_end_termination_select <= next_near_end_termination_select;
      common_mode_trim            <= next_common_mode_trim;
      line_pixel_count_lo         <= next_line_pixel_count_lo;
      line_pixel_count_hi         <= next_line_pixel_count_hi;
      common_mode_trim_mismatch   <= next_common_mode_trim_mismatch;
      prdata                      <= next_prdata;
    end
  end

  // The two halves only ever form one twelve-bit count.
  assign line_pixel_count = {line_pixel_count_hi, line_pixel_count_lo};

  // The switch is a flop stage, so a change of order lands on all lanes
  // in the same cycle and never shows a half-swapped set of pins.
  lvcfg_lane_remap u_remap (
    .core_clk (core_clk),
    .srst     (srst),
    .flip     (lane_order_flip),
    .in_pos   (ser_lane_pos),
    .in_neg   (ser_lane_neg),
    .out_pos  (pin_pos),
    .out_neg  (pin_neg)
  );

  assign out_lane0_pos = pin_pos[0];
  assign out_lane0_neg = pin_neg[0];
  assign out_lane1_pos = pin_pos[1];
  assign out_lane1_neg = pin_neg[1];
  assign out_lane2_pos = pin_pos[2];
  assign out_lane2_neg = pin_neg[2];
  assign out_lane3_pos = pin_pos[3];
  assign out_lane3_neg = pin_neg[3];
  assign out_clock_pos = pin_pos[4];
  assign out_clock_neg = pin_neg[4];

endmodule : lvcfg_regs

`default_nettype wire

// File: bench/lvcfg_regs_chk.sv
// Purpose: Port checks for the output channel configuration bank.
// Assumes: A write lands at the access edge and shows one edge later.
// Notes:   Lanes lag their inputs by one register stage.
`timescale 1ns/10ps
`default_nettype none
module lvcfg_regs_chk
  import lvcfg_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              srst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic [LANES-1:0]  ser_lane_pos,
  input wire logic [LANES-1:0]  ser_lane_neg,
  input wire logic              out_lane0_pos,
  input wire logic              out_lane1_neg,
  input wire logic              out_clock_pos,
  input wire logic              common_mode_select,
  input wire logic [1:0]        diff_swing_select,
  input wire logic              lane_order_flip,
  input wire logic              near_end_termination_select,
  input wire logic [1:0]        common_mode_trim,
  input wire logic [11:0]       line_pixel_count
);
  logic wr;
  assign wr = psel && penable && pready && pwrite && pstrb[0];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  AST_CM_SEL: assert property (wr && paddr == ADDR_SWING_CM |=>
    common_mode_select == $past(pwdata[6])) else $error("cm select");
  AST_SWING: assert property (wr && paddr == ADDR_SWING_CM |=>
    diff_swing_select == $past(pwdata[3:2])) else $error("swing");
  AST_FLIP: assert property (wr && paddr == ADDR_ORDER_TERM |=>
    lane_order_flip == $past(pwdata[5])) else $error("flip");
  AST_TERM: assert property (wr && paddr == ADDR_ORDER_TERM |=>
    near_end_termination_select == $past(pwdata[1])) else $error("term");
  AST_TRIM: assert property (wr && paddr == ADDR_CM_TRIM |=>
    common_mode_trim == $past(pwdata[5:4])) else $error("trim");
  AST_LEN_LO: assert property (wr && paddr == ADDR_LEN_LO |=>
    line_pixel_count[7:0] == $past(pwdata[7:0])) else $error("len lo");
  AST_LEN_HI: assert property (wr && paddr == ADDR_LEN_HI |=>
    line_pixel_count[11:8] == $past(pwdata[3:0])) else $error("len hi");
  AST_REVERSE: assert property ($past(lane_order_flip) && !$past(srst) |->
    out_lane0_pos == $past(ser_lane_pos[3]) && out_lane1_neg == $past(ser_lane_neg[4])
    && out_clock_pos == $past(ser_lane_pos[1])) else $error("reversed lanes");
  AST_RSV_ZERO: assert property (psel && penable && !pwrite && paddr == ADDR_ORDER_TERM |->
    prdata[31:6] == 26'h0 && prdata[4:2] == 3'h0 && !prdata[0]) else $error("reserved bits");
endmodule : lvcfg_regs_chk
bind lvcfg_regs lvcfg_regs_chk chk (.*);
`default_nettype wire

// File: bench/lvcfg_panel_rx.sv
// Purpose: Panel receiver model that gathers the output pins into lanes.
// Assumes: Bit 4 of each vector is the clock lane.
// Notes:   Pairs are kept apart so a swapped pos and neg shows up.
`timescale 1ns/10ps
`default_nettype none
module lvcfg_panel_rx (
  input wire logic  out_lane0_pos,
  input wire logic  out_lane0_neg,
  input wire logic  out_lane1_pos,
  input wire logic  out_lane1_neg,
  input wire logic  out_lane2_pos,
  input wire logic  out_lane2_neg,
  input wire logic  out_lane3_pos,
  input wire logic  out_lane3_neg,
  input wire logic  out_clock_pos,
  input wire logic  out_clock_neg,
  output logic [4:0] rx_pos,
  output logic [4:0] rx_neg
);
  assign rx_pos = {out_clock_pos, out_lane3_pos, out_lane2_pos, out_lane1_pos, out_lane0_pos};
  assign rx_neg = {out_clock_neg, out_lane3_neg, out_lane2_neg, out_lane1_neg, out_lane0_neg};
endmodule : lvcfg_panel_rx
`default_nettype wire

// File: bench/lvds_output_config_regs_bench.sv
// Purpose: Self-checking bench for the output channel configuration bank.
// Assumes: Every access waits on pready; no wait count is assumed.
// Notes:   An idle cycle follows each access so no signal is driven twice at one edge.
`timescale 1ns/10ps
`default_nettype none
module lvds_output_config_regs_bench
  import lvcfg_pkg::*;
;
  logic              core_clk, srst, psel, penable, pwrite, pready, pslverr, er;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [3:0]        pstrb;
  logic [LANES-1:0]  ser_lane_pos, ser_lane_neg, rx_pos, rx_neg;
  logic              out_lane0_pos, out_lane0_neg, out_lane1_pos, out_lane1_neg, out_lane2_pos;
  logic              out_lane2_neg, out_lane3_pos, out_lane3_neg, out_clock_pos, out_clock_neg;
  logic              common_mode_select, lane_order_flip, near_end_termination_select;
  logic              common_mode_trim_mismatch;
  logic [1:0]        diff_swing_select, common_mode_trim;
  logic [11:0]       line_pixel_count;
  logic [18:0]       pins;
  int                bad_count, n_checks;
  assign pins = {common_mode_select, diff_swing_select, lane_order_flip,
                 near_end_termination_select, common_mode_trim, line_pixel_count};
  lvcfg_regs dut (.*);
  lvcfg_panel_rx rx (.*);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(nm, e, rd);
    chk({nm, " err"}, 32'h0, {31'h0, er});
  endtask : rd_chk
  task automatic lane(input logic [4:0] p, input logic [4:0] e);
    ser_lane_pos <= p;
    ser_lane_neg <= ~p;
    repeat (2) @(posedge core_clk);
    #1;
    chk("lanes", {22'h0, e, ~e}, {22'h0, rx_pos, rx_neg});
    @(posedge core_clk);
  endtask : lane
  task automatic t_reset;
    rd_chk(ADDR_SWING_CM, 32'h04, "swing_cm");
    rd_chk(ADDR_ORDER_TERM, 32'h02, "order_term");
    rd_chk(ADDR_CM_TRIM, 32'h00, "trim");
    rd_chk(ADDR_LEN_LO, 32'h00, "len_lo");
    chk("pins", 32'h14000, {13'h0, pins});
    chk("mismatch", 32'h0, {31'h0, common_mode_trim_mismatch});
    rd_chk(ADDR_STATUS, 32'h00, "status");
  endtask : t_reset
  task automatic t_fields;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ADDR_CM_TRIM, {26'h0, 2'(i), 4'h0}, 4'h1);
      rd_chk(ADDR_CM_TRIM, {26'h0, 2'(i), 4'h0}, "trim");
      chk("trim pin", {30'h0, 2'(i)}, {30'h0, common_mode_trim});
    end
    apb(1'b1, ADDR_CM_TRIM, 32'h10, 4'h1);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ADDR_SWING_CM, {24'h0, 2'h1, 2'h0, 2'(i), 2'h0}, 4'h1);
      rd_chk(ADDR_SWING_CM, {24'h0, 2'h1, 2'h0, 2'(i), 2'h0}, "swing_cm");
      chk("cm pins", {29'h0, 1'b1, 2'(i)}, {29'h0, common_mode_select, diff_swing_select});
    end
    chk("mismatch", 32'h0, {31'h0, common_mode_trim_mismatch});
    apb(1'b1, ADDR_CM_TRIM, 32'h20, 4'h1);
    chk("mismatch", 32'h1, {31'h0, common_mode_trim_mismatch});
    apb(1'b1, ADDR_STATUS, 32'h00, 4'h1);
    rd_chk(ADDR_STATUS, 32'h01, "status");
    apb(1'b1, ADDR_CM_TRIM, 32'h10, 4'h1);
    chk("mismatch", 32'h0, {31'h0, common_mode_trim_mismatch});
  endtask : t_fields
  task automatic t_lanes;
    apb(1'b1, ADDR_ORDER_TERM, 32'h00, 4'h1);
    lane(5'h13, 5'h13);
    chk("term", 32'h0, {31'h0, near_end_termination_select});
    apb(1'b1, ADDR_ORDER_TERM, 32'hff, 4'h1);
    rd_chk(ADDR_ORDER_TERM, 32'h22, "order_term");
    chk("term", 32'h1, {31'h0, near_end_termination_select});
    rd_chk(ADDR_STATUS, 32'h02, "status");
    lane(5'h13, 5'h1a);
    lane(5'h0c, 5'h05);
  endtask : t_lanes
  task automatic t_refuse;
    apb(1'b1, 12'h000, 32'hff, 4'h1);
    chk("unmapped", 32'h1, {31'h0, er});
    apb(1'b0, 12'h000, 32'h0, 4'h0);
    chk("unmapped rd", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, ADDR_SWING_CM, 32'hff, 4'h1);
    rd_chk(ADDR_SWING_CM, 32'h4c, "swing_cm");
    apb(1'b1, ADDR_LEN_LO, 32'hff, 4'h1);
    apb(1'b1, ADDR_LEN_HI, 32'hff, 4'h1);
    rd_chk(ADDR_LEN_HI, 32'h0f, "len_hi");
    chk("len pin", 32'hfff, {20'h0, line_pixel_count});
    apb(1'b1, ADDR_LEN_LO, 32'ha5, 4'h0);
    rd_chk(ADDR_LEN_LO, 32'hff, "len_lo");
    apb(1'b1, ADDR_LEN_LO, 32'ha5, 4'h1);
    rd_chk(ADDR_LEN_LO, 32'ha5, "len_lo");
    chk("len pin", 32'hfa5, {20'h0, line_pixel_count});
  endtask : t_refuse
  task automatic finish_test;
    if (bad_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    {srst, psel, penable, pwrite, paddr, pwdata, pstrb} = {1'b1, 51'h0};
    {ser_lane_pos, ser_lane_neg, bad_count, n_checks} = '0;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    t_reset();
    t_fields();
    t_lanes();
    t_refuse();
    // A reset in mid-run must bring every field but the termination select back from non-default values.
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    t_reset();
    finish_test();
  end
  initial begin
    repeat (2000) @(posedge core_clk);
    bad_count++;
    finish_test();
  end
endmodule : lvds_output_config_regs_bench
`default_nettype wire
